/* design/srwob_top.sv */
`timescale 1ns/1ps
module srwob_top #(
   parameter int unsigned SYNC_DEPTH = srwob_pkg::SYNC_STAGES
) (
   input  wire logic                  clk_in,
   input  wire logic                  reset_in,
   input  wire logic                  sleep_in,
   input  wire logic                  rx_line_in,
   input  wire srwob_pkg::srwob_ctrl_t ctrl_in,
   output logic                       baud_clock_enable_out,
   output srwob_pkg::srwob_stat_t     stat_out
);
   import srwob_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // A single stage would let a metastable sample reach the edge detectors.
   if (SYNC_DEPTH < 2) begin : g_depth_check
      $error("SYNC_DEPTH must be at least two.");
   end

   // ****************************************************************
   // State decoding
   // ****************************************************************
   // Wake enable reads back as set while armed and while inside the break.
   function automatic logic is_engaged(input srwob_state_t state);
      is_engaged = (state != SRWOB_NORMAL);
   endfunction

   // ****************************************************************
   // Receive line synchroniser
   // ****************************************************************
   // More stages buy margin against metastability at the cost of wake latency.
   logic [SYNC_DEPTH-1:0] sync_q;
   logic                  line_w;
   logic                  prev_q;
   logic                  fall_w;
   logic                  rise_w;

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync_q[0] <= RX_LINE_IDLE;
      end else begin
         sync_q[0] <= rx_line_in;
      end
   end

   for (genvar g = 1; g < SYNC_DEPTH; g++) begin : g_line_sync
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            sync_q[g] <= RX_LINE_IDLE;
         end else begin
            sync_q[g] <= sync_q[g-1];
         end
      end
   end

   // Only the last stage feeds logic; earlier stages may still be settling.
   assign line_w = sync_q[SYNC_DEPTH-1];

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         prev_q <= RX_LINE_IDLE;
      end else begin
         prev_q <= line_w;
      end
   end

   assign fall_w = prev_q & ~line_w;
   assign rise_w = ~prev_q & line_w;

   // ****************************************************************
   // Clockless wake catch for sleep
   // ****************************************************************
   // While asleep the clock is gated, so the falling edge itself sets a
   // latch flop; it is released only once the clocked side has seen it.
   logic                  armed_w;
   logic                  sleep_edge_q;
   logic                  ack_q;
   logic [SYNC_DEPTH-1:0] edge_sync_q;
   logic                  edge_seen_w;
   logic                  clr_async_w;

   assign clr_async_w = reset_in | ack_q;

   always_ff @(negedge rx_line_in or posedge clr_async_w) begin
      if (clr_async_w) begin
         sleep_edge_q <= 1'b0;
      end else if (armed_w && sleep_in) begin
         sleep_edge_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         edge_sync_q[0] <= 1'b0;
      end else begin
         edge_sync_q[0] <= sleep_edge_q;
      end
   end

   for (genvar g = 1; g < SYNC_DEPTH; g++) begin : g_edge_sync
      always_ff @(posedge clk_in or posedge reset_in) begin
         if (reset_in) begin
            edge_sync_q[g] <= 1'b0;
         end else begin
            edge_sync_q[g] <= edge_sync_q[g-1];
         end
      end
   end

   assign edge_seen_w = edge_sync_q[SYNC_DEPTH-1];

   // The catch flop is released only after the clocked side has held the
   // edge for a full cycle, so a wake that arrives in sleep cannot be lost.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= edge_seen_w;
      end
   end

   // ****************************************************************
   // Wake state machine
   // ****************************************************************
   srwob_state_t state_q;
   logic         wake_event_w;

   assign armed_w      = (state_q == SRWOB_ARMED);
   // Async mode is checked on the event as well, since leaving it drops the arm.
   assign wake_event_w = armed_w && ctrl_in.async_mode && (fall_w || edge_seen_w);

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_q <= SRWOB_NORMAL;
      end else begin
         case (state_q)
            SRWOB_NORMAL: begin
               if (ctrl_in.set_wake && ctrl_in.async_mode) begin
                  state_q <= SRWOB_ARMED;
               end
            end
            SRWOB_ARMED: begin
               if (wake_event_w) begin
                  state_q <= SRWOB_IN_BREAK;
               end else if (ctrl_in.clear_wake || !ctrl_in.async_mode) begin
                  state_q <= SRWOB_NORMAL;
               end
            end
            SRWOB_IN_BREAK: begin
               // A rising edge seen while still asleep is ignored; software
               // must then clear the enable itself.
               if (rise_w && !sleep_in) begin
                  state_q <= SRWOB_NORMAL;
               end else if (ctrl_in.clear_wake) begin
                  state_q <= SRWOB_NORMAL;
               end
            end
            default: begin
               state_q <= SRWOB_NORMAL;
            end
         endcase
      end
   end

   // ****************************************************************
   // Interrupt flag and outputs
   // ****************************************************************
   logic         flag_q;

   // Set wins over a holding read in the same cycle, so a wake is never lost.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         flag_q <= RX_FLAG_RESET;
      end else if (wake_event_w) begin
         flag_q <= 1'b1;
      end else if (ctrl_in.holding_read) begin
         flag_q <= 1'b0;
      end
   end

   // Every output port is registered once more so that it comes straight from a flop.
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         stat_out <= '0;
      end else begin
         stat_out.wake_on_break_enable   <= is_engaged(state_q);
         stat_out.receive_interrupt_flag <= flag_q;
         stat_out.rx_sequence_enable     <= !is_engaged(state_q);
         stat_out.wake_request           <= flag_q && is_engaged(state_q);
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         baud_clock_enable_out <= 1'b0;
      end else begin
         baud_clock_enable_out <= !sleep_in;
      end
   end

endmodule

/* design/srwob_pkg.sv */
package srwob_pkg;

   // ****************************************************************
   // Control field positions and reset values
   // ****************************************************************
   localparam int unsigned WAKE_ENABLE_BIT   = 1;
   localparam logic        WAKE_ENABLE_RESET = 1'b0;
   localparam logic        RX_FLAG_RESET     = 1'b0;
   localparam logic        RX_LINE_IDLE      = 1'b1;
   localparam int unsigned SYNC_STAGES       = 2;

   typedef enum logic [1:0] {
      SRWOB_NORMAL,
      SRWOB_ARMED,
      SRWOB_IN_BREAK
   } srwob_state_t;

   // Control strobes from the processor side, same clock domain.
   typedef struct packed {
      logic async_mode;
      logic set_wake;
      logic clear_wake;
      logic holding_read;
   } srwob_ctrl_t;

   // Status seen by the rest of the receiver and by software.
   typedef struct packed {
      logic wake_on_break_enable;
      logic receive_interrupt_flag;
      logic rx_sequence_enable;
      logic wake_request;
   } srwob_stat_t;

endpackage

/* test/srwob_properties.sv */
`timescale 1ns/1ps
module srwob_properties import srwob_pkg::*; (
   input wire logic        clk_in,
   input wire logic        reset_in,
   input wire logic        sleep_in,
   input wire logic        rx_line_in,
   input wire srwob_ctrl_t ctrl_in,
   input wire logic        baud_clock_enable_out,
   input wire srwob_stat_t stat_out);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   wire en = stat_out.wake_on_break_enable, fl = stat_out.receive_interrupt_flag;
   wire sw = ctrl_in.set_wake, am = ctrl_in.async_mode, hr = ctrl_in.holding_read;
   wire bc = baud_clock_enable_out, rs = stat_out.rx_sequence_enable;
   sequence s_fall; en && !sleep_in && !fl && $fell(rx_line_in); endsequence
   sequence s_rise; en && fl && !sleep_in && $rose(rx_line_in); endsequence
   chk_baud_stop: assert property (sleep_in |=> !bc) else $error("baud on");
   chk_sync_only: assert property (sw && !am && !en |-> ##2 !en) else $error("armed");
   chk_arm_delay: assert property (sw && am && !en |-> ##2 en) else $error("unarmed");
   chk_rx_held: assert property (en |-> !rs) else $error("rx on");
   chk_fall_flag: assert property (s_fall |-> ##[1:6] fl) else $error("no flag");
   chk_sync_wait: assert property (s_fall |=> !fl [*2]) else $error("early flag");
   chk_read_clear: assert property (hr && !en |-> ##2 !fl) else $error("flag held");
   chk_rise_disarm: assert property (s_rise |-> ##[1:6] !en) else $error("armed");
endmodule
bind srwob_top srwob_properties u_chk (.clk_in, .reset_in, .sleep_in, .rx_line_in, .ctrl_in,
   .baud_clock_enable_out, .stat_out);

/* test/srwob_node.sv */
`timescale 1ns/1ps
module srwob_node (input wire logic clk_in, input wire logic start_in, output logic rx_line_out);
   int cnt = 0;
   always @(posedge clk_in) cnt <= cnt != 0 ? cnt - 1 : start_in ? 48 : 0;
   assign rx_line_out = cnt == 0;
endmodule

/* test/srwob_top_tb.sv */
`timescale 1ns/1ps
module srwob_top_tb;
   logic clk_in = 1'b0, reset_in = 1'b1, sleep = 1'b0, rx;
   logic [4:0] drv = 5'h00;
   wire [4:0] obs;
   int bad_count = 0, n_compared = 0;
   always #12.5 clk_in = ~clk_in;
   srwob_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .sleep_in(sleep), .rx_line_in(rx),
      .ctrl_in(srwob_pkg::srwob_ctrl_t'(drv[3:0])), .baud_clock_enable_out(obs[4]),
      .stat_out(obs[3:0]));
   srwob_node u_node (.clk_in(clk_in), .start_in(drv[4]), .rx_line_out(rx));
   task chk(input int n, input int i, input logic e);
      repeat (n) @(posedge clk_in);
      #1 n_compared++;
      if (obs[i] !== e) bad_count++;
      if (obs[i] !== e) $display("MISMATCH %0t %h %h", $time, obs[i], e);
   endtask
   task pulse(input int b);
      @(posedge clk_in) drv[b] <= 1'b1;
      @(posedge clk_in) drv[b] <= 1'b0;
   endtask
   task finish_test(input int hang);
      bad_count += hang;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task t_awake;
      pulse(2);
      chk(4, 3, 1'b0);
      @(posedge clk_in) drv[3] <= 1'b1;
      pulse(2);
      chk(3, 1, 1'b0);
      pulse(4);
      chk(7, 2, 1'b1);
      chk(0, 0, 1'b1);
      chk(50, 3, 1'b0);
      chk(0, 2, 1'b1);
      pulse(0);
      chk(3, 2, 1'b0);
   endtask
   task t_sleep;
      pulse(2);
      @(posedge clk_in) sleep <= 1'b1;
      chk(2, 4, 1'b0);
      pulse(4);
      chk(58, 3, 1'b1);
      @(posedge clk_in) sleep <= 1'b0;
      chk(8, 2, 1'b1);
      pulse(1);
      pulse(0);
      chk(3, 2, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge clk_in);
      reset_in <= 1'b0;
      t_awake();
      t_sleep();
      finish_test(0);
   end
   initial #20us finish_test(1);
endmodule
